// ### inc/tmf_params.svh
// Constants for the test-mode contact forcing block
`ifndef TMF_PARAMS_SVH
`define TMF_PARAMS_SVH

// ********************************************
// Register offsets (word index on the plain bus)
// ********************************************
`define TMF_ADDR_W 4
`define TMF_OFF_CTRL 4'h0
`define TMF_OFF_IN_FORCE 4'h1
`define TMF_OFF_OUT_FORCE 4'h2
`define TMF_OFF_STATUS 4'h3
`define TMF_OFF_IN_STATE 4'h4
`define TMF_OFF_OUT_STATE 4'h5

// ********************************************
// Field positions
// ********************************************
`define TMF_CTRL_EN_BIT 0
`define TMF_CTRL_SEL_BIT 1
`define TMF_STAT_ACT_BIT 0
`define TMF_STAT_LED_BIT 1

// ********************************************
// Sizes and reset values
// ********************************************
`define TMF_N_IN 16
`define TMF_N_OUT 16
`define TMF_CTRL_RST 2'h0

// ********************************************
// Timing
// ********************************************
`define TMF_CLK_NS 10
`define TMF_FLASH_HALF_MS 250
`define TMF_FLASH_HALF_CYC ((`TMF_FLASH_HALF_MS * 1000000) / `TMF_CLK_NS)

`endif

// ### inc/tmf_pkg.sv
// Types shared by the test-mode contact forcing block
package tmf_pkg;

    // Per-input force choice
    typedef enum logic [1:0] {
        TMF_IN_DISABLED = 2'h0,
        TMF_IN_OPEN = 2'h1,
        TMF_IN_CLOSED = 2'h2
    } tmf_in_force_t;

    // Per-output force choice
    typedef enum logic [1:0] {
        TMF_OUT_DISABLED = 2'h0,
        TMF_OUT_ENERGIZE = 2'h1,
        TMF_OUT_DEENERGIZE = 2'h2,
        TMF_OUT_FREEZE = 2'h3
    } tmf_out_force_t;

    // Test-mode states
    typedef enum logic [1:0] {
        TMF_ST_IDLE = 2'h0,
        TMF_ST_ACTIVE = 2'h1,
        TMF_ST_WAIT = 2'h2
    } tmf_state_t;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tmf_bus_req_t;

endpackage : tmf_pkg

// ### hw/tmf_flasher.sv
// Square-wave generator for the test indicator
`timescale 1ns/10ps
`include "tmf_params.svh"
module tmf_flasher import tmf_pkg::*; #(
    parameter int unsigned HALF_CYC = `TMF_FLASH_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic run_i,
    output logic led_o
);
    logic [31:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= 32'h0;
            led_o <= 1'b0;
        end else if (ce_i) begin
            if (!run_i) begin
                cnt_reg <= 32'h0;
                led_o <= 1'b0;
            end else if (cnt_reg >= HALF_CYC - 1) begin
                cnt_reg <= 32'h0;
                led_o <= ~led_o;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end
endmodule : tmf_flasher

// ### hw/tmf_force_lane.sv
// Forcing of one contact input and one contact output
`timescale 1ns/10ps
module tmf_force_lane import tmf_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic test_i,
    input wire logic enter_i,
    input wire tmf_in_force_t in_force_i,
    input wire tmf_out_force_t out_force_i,
    input wire logic sensed_i,
    input wire logic operand_i,
    output logic in_next_o,
    output logic out_next_o
);
    logic frz_reg;

    // Freeze snapshot taken from the live operand on the entry cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            frz_reg <= 1'b0;
        end else if (ce_i && enter_i) begin
            frz_reg <= operand_i; // [RL14]
        end
    end

    always_comb begin
        in_next_o = sensed_i; // [RL7]
        if (test_i) begin
            case (in_force_i)
                TMF_IN_OPEN: in_next_o = 1'b0; // [RL8]
                TMF_IN_CLOSED: in_next_o = 1'b1; // [RL9]
                default: in_next_o = sensed_i; // [RL7]
            endcase
        end
    end

    always_comb begin
        out_next_o = operand_i; // [RL11]
        if (test_i) begin
            case (out_force_i)
                TMF_OUT_ENERGIZE: out_next_o = 1'b1; // [RL12]
                TMF_OUT_DEENERGIZE: out_next_o = 1'b0; // [RL13]
                // The snapshot is still loading on the entry cycle
                TMF_OUT_FREEZE: begin
                    out_next_o = enter_i ? operand_i : frz_reg; // [RL14]
                end
                default: out_next_o = operand_i; // [RL11]
            endcase
        end
    end
endmodule : tmf_force_lane

// ### hw/tmf_test_mode.sv
// Test-mode controller with per-contact input and output forcing
// Summary of operation
// [RL1] Test mode is active only while enabled and the trigger is 1.
// [RL2] With the fixed-on trigger, enabling starts test mode.
// [RL3] With the operand trigger, a 1 on the operand starts test mode.
// [RL4] While active, the test indicator flashes.
// [RL5] Nothing but the contact inputs and outputs is touched.
// [RL6] Each contact input and output has its own force setting.
// [RL7] A disabled input force passes the sensed level.
// [RL8] An open input force reports 0 throughout test mode.
// [RL9] A closed input force reports 1 throughout test mode.
// [RL10] With all input forces disabled, inputs report what they sense.
// [RL11] A disabled output force follows its operand, also in test mode.
// [RL12] An energize output force closes the contact in test mode.
// [RL13] A de-energize output force opens the contact in test mode.
// [RL14] A freeze output force holds the pre-test state in test mode.
// [RL15] Dropping enable or trigger ends test mode at once.
`timescale 1ns/10ps
`include "tmf_params.svh"
module tmf_test_mode import tmf_pkg::*; #(
    parameter int unsigned FLASH_HALF_CYC = `TMF_FLASH_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic trig_operand_i,
    input wire logic [`TMF_N_IN-1:0] contact_input_i,
    input wire logic [`TMF_N_OUT-1:0] operand_i,
    output logic [`TMF_N_IN-1:0] contact_input_o,
    output logic [`TMF_N_OUT-1:0] contact_output_o,
    output logic test_active_o,
    output logic test_led_o
);

    // ********************************************
    // Settings registers
    // ********************************************
    logic [1:0] ctrl_reg;
    logic [31:0] in_force_reg;
    logic [31:0] out_force_reg;
    tmf_state_t state_reg;
    tmf_state_t state_next;
    logic trig_prev_reg;
    logic led_w;
    logic enter_w;
    logic test_w;
    logic trig_w;
    logic [`TMF_N_IN-1:0] in_next;
    logic [`TMF_N_OUT-1:0] out_next;
    tmf_bus_req_t req;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction : hit

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `TMF_CTRL_RST;
        end else if (ce_i && req.wr && hit(req.addr, `TMF_OFF_CTRL)) begin
            ctrl_reg <= req.wdata[1:0];
        end
    end

    // Two force bits per contact, one independent field each
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            in_force_reg <= 32'h0;
            out_force_reg <= 32'h0;
        end else if (ce_i && req.wr) begin
            if (hit(req.addr, `TMF_OFF_IN_FORCE)) begin
                in_force_reg <= req.wdata; // [RL6]
            end
            if (hit(req.addr, `TMF_OFF_OUT_FORCE)) begin
                out_force_reg <= req.wdata; // [RL6]
            end
        end
    end

    // ********************************************
    // Test-mode decision
    // ********************************************
    // Selector 0 is the fixed-on trigger, 1 the external operand
    assign trig_w = ctrl_reg[`TMF_CTRL_SEL_BIT] ? trig_operand_i : 1'b1;

    // Level-started: enable and trigger both high starts test mode, which
    // also covers the enable edge under the fixed-on trigger.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TMF_ST_IDLE: begin
                if (ctrl_reg[`TMF_CTRL_EN_BIT] && trig_w) begin
                    state_next = TMF_ST_ACTIVE; // [RL2] [RL3]
                end
            end
            TMF_ST_ACTIVE: begin
                if (!ctrl_reg[`TMF_CTRL_EN_BIT] || !trig_w) begin
                    state_next = TMF_ST_IDLE; // [RL15]
                end
            end
            default: state_next = TMF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= TMF_ST_IDLE;
            trig_prev_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next; // [RL1]
            trig_prev_reg <= trig_w;
        end
    end

    // Forcing follows the next state so it lands with test_active_o
    assign test_w = (state_next == TMF_ST_ACTIVE);
    assign enter_w = (state_reg == TMF_ST_IDLE) && test_w;

    tmf_flasher #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .run_i(state_reg == TMF_ST_ACTIVE),
        .led_o(led_w)
    );

    // ********************************************
    // Contact forcing lanes
    // ********************************************
    // Only contact paths pass through here; outside them only the flasher, test_active_o and the status read see test mode
    genvar g;
    generate
        for (g = 0; g < `TMF_N_IN; g++) begin : g_lane
            tmf_force_lane u_lane (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .ce_i(ce_i),
                .test_i(test_w),
                .enter_i(enter_w),
                .in_force_i(tmf_in_force_t'(in_force_reg[2*g +: 2])),
                .out_force_i(tmf_out_force_t'(out_force_reg[2*g +: 2])),
                .sensed_i(contact_input_i[g]),
                .operand_i(operand_i[g]),
                .in_next_o(in_next[g]),
                .out_next_o(out_next[g])
            ); // [RL5]
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            contact_input_o <= '0;
            contact_output_o <= '0;
            test_active_o <= 1'b0;
            test_led_o <= 1'b0;
        end else if (ce_i) begin
            contact_input_o <= in_next; // [RL10]
            contact_output_o <= out_next;
            test_active_o <= test_w;
            test_led_o <= led_w; // [RL4]
        end
    end

    // ********************************************
    // Register read
    // ********************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0;
        end else if (ce_i) begin
            rdata_o <= 32'h0;
            if (req.rd) begin
                case (req.addr)
                    `TMF_OFF_CTRL: rdata_o <= {30'h0, ctrl_reg};
                    `TMF_OFF_IN_FORCE: rdata_o <= in_force_reg;
                    `TMF_OFF_OUT_FORCE: rdata_o <= out_force_reg;
                    `TMF_OFF_STATUS:
                        rdata_o <= {30'h0, test_led_o, test_active_o};
                    `TMF_OFF_IN_STATE: rdata_o <= {16'h0, contact_input_o};
                    `TMF_OFF_OUT_STATE: rdata_o <= {16'h0, contact_output_o};
                    default: rdata_o <= 32'h0;
                endcase
            end
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    // Lane 0 and lane 15 stand for every lane, which share one module
    chk_active_needs_en: assert property ( // [RL1]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w |-> ctrl_reg[`TMF_CTRL_EN_BIT] && trig_w)
        else $error("test mode without enable and trigger");

    chk_enter_level: assert property ( // [RL1]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && ctrl_reg[`TMF_CTRL_EN_BIT] && trig_w |=> test_active_o)
        else $error("enable and trigger did not start test mode");

    chk_status_active: assert property ( // [RL1]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && rd_i && addr_i == `TMF_OFF_STATUS
        |=> rdata_o[`TMF_STAT_ACT_BIT] == $past(test_active_o))
        else $error("status does not show test mode");

    chk_fixed_on_start: assert property ( // [RL2]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && !ctrl_reg[`TMF_CTRL_SEL_BIT]
        && $rose(ctrl_reg[`TMF_CTRL_EN_BIT]) |-> test_w)
        else $error("fixed trigger did not start test mode");

    chk_operand_start: assert property ( // [RL3]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && ctrl_reg == 2'h3 && trig_operand_i && !trig_prev_reg
        |=> test_active_o)
        else $error("operand did not start test mode");

    chk_led_idle: assert property ( // [RL4]
        @(posedge clk_i) disable iff (!rstn_i)
        !test_active_o && ce_i |=> ##1 (!test_led_o || test_active_o))
        else $error("indicator lit outside test mode");

    chk_in_disabled: assert property ( // [RL7]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w
        && (in_force_reg[1:0] == 2'h0 || in_force_reg[1:0] == 2'h3)
        |=> contact_input_o[0] == $past(contact_input_i[0]))
        else $error("disabled input not sensed in test mode");

    chk_in_open: assert property ( // [RL8]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && in_force_reg[1:0] == 2'h1 |=> !contact_input_o[0])
        else $error("open input not forced low");

    chk_in_closed: assert property ( // [RL9]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && in_force_reg[1:0] == 2'h2 |=> contact_input_o[0])
        else $error("closed input not forced high");

    chk_in_last_lane: assert property ( // [RL6]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && in_force_reg[31:30] == 2'h2
        |=> contact_input_o[15])
        else $error("last input lane not forced high");

    chk_in_normal: assert property ( // [RL10]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && (in_force_reg == 32'h0 || !test_w)
        |=> contact_input_o == $past(contact_input_i))
        else $error("input not sensed normally");

    chk_out_follow: assert property ( // [RL11]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && (out_force_reg[1:0] == 2'h0 || !test_w)
        |=> contact_output_o[0] == $past(operand_i[0]))
        else $error("output not following operand");

    chk_out_test_follow: assert property ( // [RL11]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && out_force_reg[1:0] == 2'h0
        |=> contact_output_o[0] == $past(operand_i[0]))
        else $error("disabled output not following in test mode");

    chk_out_energize: assert property ( // [RL12]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && out_force_reg[1:0] == 2'h1 |=> contact_output_o[0])
        else $error("energized output open");

    chk_out_deenergize: assert property ( // [RL13]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && out_force_reg[1:0] == 2'h2 |=> !contact_output_o[0])
        else $error("de-energized output closed");

    chk_out_last_lane: assert property ( // [RL6]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_w && out_force_reg[31:30] == 2'h2
        |=> !contact_output_o[15])
        else $error("last output lane not forced open");

    chk_out_freeze: assert property ( // [RL14]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && enter_w && out_force_reg[1:0] == 2'h3
        |=> contact_output_o[0] == $past(operand_i[0]))
        else $error("frozen output wrong");

    chk_freeze_last_lane: assert property ( // [RL14]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && enter_w && out_force_reg[31:30] == 2'h3
        |=> contact_output_o[15] == $past(operand_i[15]))
        else $error("last frozen output lane wrong");

    chk_exit_prompt: assert property ( // [RL15]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_active_o && !ctrl_reg[`TMF_CTRL_EN_BIT]
        |=> !test_active_o)
        else $error("test mode not left");

    chk_exit_trigger: assert property ( // [RL15]
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && test_active_o && ctrl_reg[`TMF_CTRL_SEL_BIT]
        && !trig_operand_i |=> !test_active_o)
        else $error("test mode not left on trigger drop");

    chk_rdata_idle: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not cleared");

endmodule : tmf_test_mode

// ### test/tmf_contact_model.sv
// Behavioural model of the contact input and output circuits
`timescale 1ns/10ps
`include "tmf_params.svh"
module tmf_contact_model (
    input wire logic clk_i,
    input wire logic [`TMF_N_IN-1:0] terminal_i,
    input wire logic [`TMF_N_OUT-1:0] contact_output_i,
    output logic [`TMF_N_IN-1:0] sensed_o,
    output logic [`TMF_N_OUT-1:0] closed_o
);
    // Wiring settles one cycle after a terminal change, like a real input
    initial begin
        sensed_o = '0;
        closed_o = '0;
    end
    always @(posedge clk_i) begin
        sensed_o <= terminal_i;
        closed_o <= contact_output_i;
    end
endmodule : tmf_contact_model

// ### test/test_tmf_test_mode.sv
// Self-checking bench of the test-mode contact forcing block
`timescale 1ns/10ps
`include "tmf_params.svh"
module test_tmf_test_mode;
    import tmf_pkg::*;
    logic clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic ce_i = 1'h1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [31:0] rdata_o;
    logic trig_operand_i = 1'h0;
    logic [15:0] terminal = 16'h0;
    logic [15:0] sensed;
    logic [15:0] operand_i = 16'h0;
    logic [15:0] contact_input_o;
    logic [15:0] contact_output_o;
    logic [15:0] closed;
    logic test_active_o;
    logic test_led_o;
    logic [31:0] seed = 32'hCE865751;
    int n_mismatch = 0;
    int checks = 0;

    always #5 clk_i = ~clk_i;

    tmf_test_mode #(.FLASH_HALF_CYC(4)) dut_u (.clk_i(clk_i),
        .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .trig_operand_i(trig_operand_i), .contact_input_i(sensed),
        .operand_i(operand_i), .contact_input_o(contact_input_o),
        .contact_output_o(contact_output_o), .test_active_o(test_active_o),
        .test_led_o(test_led_o));
    tmf_contact_model model_u (.clk_i(clk_i), .terminal_i(terminal),
        .contact_output_i(contact_output_o), .sensed_o(sensed),
        .closed_o(closed));

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] exp_in(logic [31:0] f, logic [15:0] s,
                                           logic t);
        logic [15:0] r;
        r = s;
        for (int i = 0; i < 16; i++) begin
            if (t && f[2*i +: 2] == 2'h1) r[i] = 1'h0;
            if (t && f[2*i +: 2] == 2'h2) r[i] = 1'h1;
        end
        return r;
    endfunction : exp_in

    function automatic logic [15:0] exp_out(logic [31:0] f, logic [15:0] op,
                                            logic [15:0] fr, logic t);
        logic [15:0] r;
        r = op;
        for (int i = 0; i < 16; i++) begin
            if (t && f[2*i +: 2] == 2'h1) r[i] = 1'h1;
            if (t && f[2*i +: 2] == 2'h2) r[i] = 1'h0;
            if (t && f[2*i +: 2] == 2'h3) r[i] = fr[i];
        end
        return r;
    endfunction : exp_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        d = rdata_o;
    endtask : rd

    // Long enough for the model's extra cycle and the registered outputs
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic finish_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin : watchdog
        #100000;
        n_mismatch++;
        finish_test();
    end

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin : main
        logic [31:0] v;
        logic [31:0] fi;
        logic [31:0] fo;
        logic [15:0] fr;
        logic [31:0] l;
        logic en;
        logic sel;
        logic t;
        int n;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'h1;
        settle();
        chk(test_active_o, 1'h0);
        rd(`TMF_OFF_CTRL, v);
        chk(v, 32'h0);
        wr(4'hA, 32'hFFFFFFFF);
        rd(4'hA, v);
        chk(v, 32'h0);
        // Writes while the clock enable is low must not be taken
        ce_i <= 1'h0;
        wr(`TMF_OFF_CTRL, 32'h1);
        ce_i <= 1'h1;
        settle();
        chk(test_active_o, 1'h0);
        for (int k = 0; k < 24; k++) begin
            wr(`TMF_OFF_CTRL, 32'h0);
            fi = rnd();
            fo = rnd();
            // First pass: fixed-on trigger with every output frozen
            if (k == 0) fo = 32'hFFFFFFFF;
            wr(`TMF_OFF_IN_FORCE, fi);
            wr(`TMF_OFF_OUT_FORCE, fo);
            rd(`TMF_OFF_IN_FORCE, v);
            chk(v, fi);
            v = rnd();
            operand_i <= v[15:0];
            terminal <= v[31:16];
            settle();
            fr = operand_i;
            v = rnd();
            if (k == 0) v = 32'h1;
            en = v[0] | v[2];
            sel = v[1];
            trig_operand_i <= v[3];
            wr(`TMF_OFF_CTRL, {30'h0, sel, en});
            settle();
            t = en & (~sel | v[3]);
            chk(test_active_o, t);
            chk(contact_input_o, exp_in(fi, terminal, t));
            v = rnd();
            operand_i <= v[15:0];
            terminal <= v[31:16];
            settle();
            chk(contact_input_o, exp_in(fi, terminal, t));
            chk(closed, exp_out(fo, operand_i, fr, t));
            chk(contact_output_o, exp_out(fo, operand_i, fr, t));
            rd(`TMF_OFF_OUT_STATE, v);
            chk(v, exp_out(fo, operand_i, fr, t));
            rd(`TMF_OFF_IN_STATE, v);
            chk(v, exp_in(fi, terminal, t));
            rd(`TMF_OFF_STATUS, v);
            chk(v[`TMF_STAT_ACT_BIT], t);
            wr(`TMF_OFF_IN_FORCE, 32'h0);
            settle();
            chk(contact_input_o, terminal);
            wr(`TMF_OFF_CTRL, 32'h0);
            settle();
            chk(test_active_o, 1'h0);
            chk(contact_output_o, operand_i);
        end
        // Operand trigger with a flashing indicator
        trig_operand_i <= 1'h0;
        wr(`TMF_OFF_CTRL, 32'h3);
        settle();
        chk(test_active_o, 1'h0);
        chk(test_led_o, 1'h0);
        trig_operand_i <= 1'h1;
        settle();
        chk(test_active_o, 1'h1);
        n = 0;
        l = test_led_o;
        repeat (16) begin
            @(posedge clk_i);
            #1;
            if (test_led_o !== l[0]) n++;
            l = test_led_o;
        end
        chk(n, 4);
        trig_operand_i <= 1'h0;
        settle();
        chk(test_active_o, 1'h0);
        chk(test_led_o, 1'h0);
        rd(`TMF_OFF_STATUS, v);
        chk(v, 32'h0);
        finish_test();
    end
endmodule : test_tmf_test_mode
